// *** hdl/cpu_unit.sv ***
/*
 * clock and power unit slice: register map, debug freeze of the
 * realtime interrupt and watchdog counters, reset pin, crystal pin
 * pull-downs, periodic clock out pin and sense voltage select.
 * assumes an 8-bit register port, read data one cycle after strobe,
 * and analog pads that resolve the pin enables.
 */
// The strobed register port was left to the implementer.
//
// Function
// - freeze mode equals run, except two counters
// - debug stop bit halts both counters
// - debug may force longest watchdog timeout
// - external low reset asynchronously restarts device
// - internal resets pull reset pin low
// - oscillator clock follows crystal input when enabled
// - oscillator disabled enables crystal pin pull-downs
// - periodic pin drives selected clock when enabled
// - sense select picks temperature or bandgap voltage
`timescale 1ns/10ps
module cpu_unit (
   input  wire logic       ref_clk_i,               // 250 MHz clock
   input  wire logic       reset_n_i,               // sync reset, low active
   input  wire logic       clk_en_i,                // clock enable
   input  wire logic [9:0] addr_i,                  // register address
   input  wire logic [7:0] wdata_i,                 // write data
   input  wire logic       wr_i,                    // write strobe
   input  wire logic       rd_i,                    // read strobe
   output logic      [7:0] rdata_o,                 // read data
   input  wire logic       background_debug_i,      // debug active
   input  wire logic       force_wdog_max_i,        // debug forces longest timeout
   input  wire logic       int_reset_req_i,         // internal reset source pulse
   input  wire logic       reset_pin_i,             // reset pin level
   output logic            reset_pin_o,             // reset pin out value
   output logic            reset_pin_oe_o,          // reset pin drive enable
   output logic            async_reset_n_o,         // device reset from pin
   input  wire logic       crystal_input_pin_i,     // crystal input level
   output logic            loop_oscillator_clock_o, // oscillator clock
   output logic            crystal_pulldown_o,      // pull-down on both crystal pins
   input  wire logic       periodic_src_a_i,        // periodic clock source 0
   input  wire logic       periodic_src_b_i,        // periodic clock source 1
   output logic            periodic_clock_out_pin_o,    // periodic clock out
   output logic            periodic_clock_out_oe_o,     // periodic clock drive
   output logic            sense_voltage_select_o,  // 1 bandgap, 0 temp sensor
   output logic            rti_tick_o,              // realtime counter wrap
   output logic            wdog_timeout_o           // watchdog expired
);
   logic [7:0]  pll_multiplier;
   logic [7:0]  reference_divider;
   logic [7:0]  pll_post_divider;
   logic [7:0]  interrupt_enables;
   logic [7:0]  clock_source_select;
   logic [7:0]  frequency_modulation;
   logic [7:0]  realtime_interrupt_rate;
   logic [7:0]  watchdog_control;
   logic [7:0]  temperature_control;
   logic [7:0]  low_voltage_control;
   logic [7:0]  periodic_interrupt_control;
   logic [7:0]  osc_control;
   logic [7:0]  next_rdata;
   logic        rst_pin_s;
   logic        crystal_output_pin_s;
   logic        src_a_s;
   logic        src_b_s;
   logic        dbg_s;
   logic        freeze;
   localparam int RTI_W_L  = cpu_pkg::RTI_W;
   localparam int WDOG_W_L = cpu_pkg::WDOG_W;
   logic [RTI_W_L-1:0]  rti_cnt;
   logic [WDOG_W_L-1:0] wdog_cnt;
   logic [2:0]  wdog_rate;
   logic [4:0]  rst_stretch;
   logic        wdog_svc;
   logic [1:0]  own_drive;

   cpu_sync2 u_sync_rst (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .d_i(reset_pin_i), .q_o(rst_pin_s));
   cpu_sync2 u_sync_crystal_output_pin (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .d_i(crystal_input_pin_i), .q_o(crystal_output_pin_s));
   cpu_sync2 u_sync_pa (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .d_i(periodic_src_a_i), .q_o(src_a_s));
   cpu_sync2 u_sync_pb (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .d_i(periodic_src_b_i), .q_o(src_b_s));
   cpu_sync2 u_sync_dbg (.ref_clk_i(ref_clk_i), .clk_en_i(clk_en_i), .d_i(background_debug_i), .q_o(dbg_s));

   // register writes, reserved bits masked off
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pll_multiplier             <= cpu_pkg::RST_PLL_MULT;
         reference_divider          <= cpu_pkg::RST_REF_DIV;
         pll_post_divider           <= cpu_pkg::RST_POST_DIV;
         interrupt_enables          <= cpu_pkg::RST_CTRL;
         clock_source_select        <= cpu_pkg::RST_CTRL;
         frequency_modulation       <= cpu_pkg::RST_CTRL;
         realtime_interrupt_rate    <= cpu_pkg::RST_CTRL;
         watchdog_control           <= cpu_pkg::RST_CTRL;
         temperature_control        <= cpu_pkg::RST_CTRL;
         low_voltage_control        <= cpu_pkg::RST_CTRL;
         periodic_interrupt_control <= cpu_pkg::RST_CTRL;
         osc_control                <= cpu_pkg::RST_CTRL;
      end else if (clk_en_i && wr_i) begin
         if (addr_i == cpu_pkg::OFF_PLL_MULT) begin
            pll_multiplier <= wdata_i;
         end else if (addr_i == cpu_pkg::OFF_REF_DIV) begin
            reference_divider <= wdata_i & cpu_pkg::MASK_REF_DIV;
         end else if (addr_i == cpu_pkg::OFF_POST_DIV) begin
            pll_post_divider <= wdata_i & cpu_pkg::MASK_POST_DIV;
         end else if (addr_i == cpu_pkg::OFF_INT_EN) begin
            interrupt_enables <= wdata_i & cpu_pkg::MASK_INT_EN;
         end else if (addr_i == cpu_pkg::OFF_CLK_SEL) begin
            clock_source_select <= wdata_i;
         end else if (addr_i == cpu_pkg::OFF_FREQ_MOD) begin
            frequency_modulation <= wdata_i & cpu_pkg::MASK_FREQ_MOD;
         end else if (addr_i == cpu_pkg::OFF_RTI_RATE) begin
            realtime_interrupt_rate <= wdata_i;
         end else if (addr_i == cpu_pkg::OFF_WDOG_CTL) begin
            watchdog_control <= wdata_i & cpu_pkg::MASK_WDOG_CTL;
         end else if (addr_i == cpu_pkg::OFF_TEMP_CTL) begin
            temperature_control <= wdata_i & cpu_pkg::MASK_TEMP_CTL;
         end else if (addr_i == cpu_pkg::OFF_LV_CTL) begin
            low_voltage_control <= wdata_i & cpu_pkg::MASK_LV_CTL;
         end else if (addr_i == cpu_pkg::OFF_PER_CTL) begin
            periodic_interrupt_control <= wdata_i & cpu_pkg::MASK_PER_CTL;
         end else if (addr_i == cpu_pkg::OFF_OSC_CTL) begin
            osc_control <= wdata_i & cpu_pkg::MASK_OSC_CTL;
         end
      end
   end

   // watchdog service write pulse
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         wdog_svc <= 1'b0;
      end else if (clk_en_i) begin
         wdog_svc <= wr_i && (addr_i == cpu_pkg::OFF_WDOG_SVC);
      end
   end

   // read decode; unmapped and reserved read zero
   always_comb begin
      next_rdata = 8'h00;
      if (addr_i == cpu_pkg::OFF_PLL_MULT) begin
         next_rdata = pll_multiplier;
      end else if (addr_i == cpu_pkg::OFF_REF_DIV) begin
         next_rdata = reference_divider;
      end else if (addr_i == cpu_pkg::OFF_POST_DIV) begin
         next_rdata = pll_post_divider;
      end else if (addr_i == cpu_pkg::OFF_FLAGS) begin
         next_rdata = {rti_tick_o, 7'h00};
      end else if (addr_i == cpu_pkg::OFF_INT_EN) begin
         next_rdata = interrupt_enables;
      end else if (addr_i == cpu_pkg::OFF_CLK_SEL) begin
         next_rdata = clock_source_select;
      end else if (addr_i == cpu_pkg::OFF_FREQ_MOD) begin
         next_rdata = frequency_modulation;
      end else if (addr_i == cpu_pkg::OFF_RTI_RATE) begin
         next_rdata = realtime_interrupt_rate;
      end else if (addr_i == cpu_pkg::OFF_WDOG_CTL) begin
         next_rdata = {watchdog_control[7:3], wdog_rate};
      end else if (addr_i == cpu_pkg::OFF_TEMP_CTL) begin
         next_rdata = temperature_control;
      end else if (addr_i == cpu_pkg::OFF_LV_CTL) begin
         next_rdata = low_voltage_control;
      end else if (addr_i == cpu_pkg::OFF_PER_CTL) begin
         next_rdata = periodic_interrupt_control;
      end else if (addr_i == cpu_pkg::OFF_OSC_CTL) begin
         next_rdata = osc_control;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
      end
   end

   // counters freeze only in debug with the stop bit set
   assign freeze = dbg_s && watchdog_control[cpu_pkg::BIT_DBG_CLK_STOP];
   // debug may force the longest rate
   assign wdog_rate = (dbg_s && force_wdog_max_i) ? cpu_pkg::WDOG_RATE_MAX : watchdog_control[2:0];

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rti_cnt    <= '0;
         rti_tick_o <= 1'b0;
      end else if (clk_en_i) begin
         rti_tick_o <= 1'b0;
         if (!freeze && realtime_interrupt_rate != 8'h00) begin
            if (rti_cnt[RTI_W_L-1:8] == {1'b0, realtime_interrupt_rate[6:0]}) begin
               rti_cnt    <= '0;
               rti_tick_o <= 1'b1;
            end else begin
               rti_cnt <= rti_cnt + 1'b1;
            end
         end
      end
   end

   // watchdog: timeout at 2^(9+2*rate) cycles
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         wdog_cnt       <= '0;
         wdog_timeout_o <= 1'b0;
      end else if (clk_en_i) begin
         wdog_timeout_o <= 1'b0;
         if (wdog_svc || wdog_rate == cpu_pkg::WDOG_RATE_OFF) begin
            wdog_cnt <= '0;
         end else if (!freeze) begin
            if (wdog_cnt[5'(9 + 2 * wdog_rate)]) begin
               wdog_cnt       <= '0;
               wdog_timeout_o <= 1'b1;
            end else begin
               wdog_cnt <= wdog_cnt + 1'b1;
            end
         end
      end
   end

   // reset pin: stretched open-drain low on internal reset
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rst_stretch    <= 5'h00;
         reset_pin_oe_o <= 1'b0;
      end else if (clk_en_i) begin
         if (int_reset_req_i || wdog_timeout_o) begin
            rst_stretch <= 5'(cpu_pkg::RST_PULSE_CYC);
         end else if (rst_stretch != 5'h00) begin
            rst_stretch <= rst_stretch - 1'b1;
         end
         reset_pin_oe_o <= int_reset_req_i || wdog_timeout_o || (rst_stretch > 5'h01);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      reset_pin_o <= 1'b0;
   end

   // synced pin lags own release by two edges; mask that tail
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         own_drive <= 2'h0;
      end else if (clk_en_i) begin
         own_drive <= {own_drive[0], reset_pin_oe_o};
      end
   end

   // external low on the pin restarts the device
   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i) begin
         async_reset_n_o <= rst_pin_s || reset_pin_oe_o || (own_drive != 2'h0);
      end
   end

   // crystal path and pull-downs
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         loop_oscillator_clock_o <= 1'b0;
         crystal_pulldown_o      <= 1'b1;
      end else if (clk_en_i) begin
         loop_oscillator_clock_o <= osc_control[cpu_pkg::BIT_OSC_EN] & crystal_output_pin_s;
         crystal_pulldown_o      <= !osc_control[cpu_pkg::BIT_OSC_EN];
      end
   end

   // periodic clock output and sense selection
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         periodic_clock_out_pin_o <= 1'b0;
         periodic_clock_out_oe_o  <= 1'b0;
         sense_voltage_select_o   <= 1'b0;
      end else if (clk_en_i) begin
         periodic_clock_out_oe_o <= periodic_interrupt_control[cpu_pkg::BIT_PER_EN];
         periodic_clock_out_pin_o <= periodic_interrupt_control[cpu_pkg::BIT_PER_EN] &&
            (periodic_interrupt_control[cpu_pkg::BIT_PER_SEL] ? src_b_s : src_a_s);
         sense_voltage_select_o <= temperature_control[cpu_pkg::BIT_SENSE_SEL];
      end
   end

   AST_PIN_OE_FOLLOWS_EN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i |=> periodic_clock_out_oe_o == $past(periodic_interrupt_control[cpu_pkg::BIT_PER_EN]))
      else $error("periodic pin enable wrong");
   AST_PIN_QUIET_OFF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !periodic_clock_out_oe_o |-> !periodic_clock_out_pin_o)
      else $error("periodic pin toggles while off");
   AST_PULLDOWN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i |=> crystal_pulldown_o == !$past(osc_control[cpu_pkg::BIT_OSC_EN]))
      else $error("pull-down not matching enable");
   AST_OSC_GATED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      crystal_pulldown_o |-> !loop_oscillator_clock_o)
      else $error("oscillator clock runs while disabled");
   AST_FREEZE_WDOG: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && freeze && !wdog_svc && wdog_rate != 3'h0) |=> $stable(wdog_cnt))
      else $error("watchdog runs while frozen");
   AST_FREEZE_RTI: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && freeze) |=> $stable(rti_cnt) && !rti_tick_o)
      else $error("realtime counter runs while frozen");
   AST_FORCE_MAX: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (dbg_s && force_wdog_max_i) |-> wdog_rate == 3'h7)
      else $error("watchdog not forced to longest");
   AST_RESET_PIN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && int_reset_req_i) |=> reset_pin_oe_o && !reset_pin_o)
      else $error("reset pin not pulled low");
   AST_SENSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_en_i |=> sense_voltage_select_o == $past(temperature_control[cpu_pkg::BIT_SENSE_SEL]))
      else $error("sense select mismatch");
   AST_RSVD_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && rd_i && (addr_i == cpu_pkg::OFF_RSVD_A || addr_i == cpu_pkg::OFF_RSVD_B)) |=> rdata_o == 8'h00)
      else $error("reserved register reads nonzero");
endmodule : cpu_unit

// *** hdl/cpu_pkg.sv ***
/*
 * constants for the clock and power unit pin and register slice:
 * register offsets, field positions, reset values, timing counts.
 * assumes an 8-bit register port with 10-bit byte addresses.
 */
package cpu_pkg;
   localparam logic [9:0] OFF_PLL_MULT    = 10'h034;
   localparam logic [9:0] OFF_REF_DIV     = 10'h035;
   localparam logic [9:0] OFF_POST_DIV    = 10'h036;
   localparam logic [9:0] OFF_FLAGS       = 10'h037;
   localparam logic [9:0] OFF_INT_EN      = 10'h038;
   localparam logic [9:0] OFF_CLK_SEL     = 10'h039;
   localparam logic [9:0] OFF_FREQ_MOD    = 10'h03a;
   localparam logic [9:0] OFF_RTI_RATE    = 10'h03b;
   localparam logic [9:0] OFF_WDOG_CTL    = 10'h03c;
   localparam logic [9:0] OFF_RSVD_A      = 10'h03d;
   localparam logic [9:0] OFF_RSVD_B      = 10'h03e;
   localparam logic [9:0] OFF_WDOG_SVC    = 10'h03f;
   localparam logic [9:0] OFF_TEMP_CTL    = 10'h2f0;
   localparam logic [9:0] OFF_LV_CTL      = 10'h2f1;
   localparam logic [9:0] OFF_PER_CTL     = 10'h2f2;
   localparam logic [9:0] OFF_OSC_CTL     = 10'h2fa;
   // implemented-bit masks
   localparam logic [7:0] MASK_REF_DIV    = 8'hcf;
   localparam logic [7:0] MASK_POST_DIV   = 8'h1f;
   localparam logic [7:0] MASK_INT_EN     = 8'h92;
   localparam logic [7:0] MASK_FREQ_MOD   = 8'h30;
   localparam logic [7:0] MASK_WDOG_CTL   = 8'hc7;
   localparam logic [7:0] MASK_TEMP_CTL   = 8'h2e;
   localparam logic [7:0] MASK_LV_CTL     = 8'h02;
   localparam logic [7:0] MASK_PER_CTL    = 8'h9e;
   localparam logic [7:0] MASK_OSC_CTL    = 8'h80;
   // field positions
   localparam int BIT_DBG_CLK_STOP        = 6;
   localparam int BIT_SENSE_SEL           = 5;
   localparam int BIT_PER_SEL             = 4;
   localparam int BIT_PER_EN              = 3;
   localparam int BIT_OSC_EN              = 7;
   localparam int BIT_RTI_DEC             = 7;
   // reset values and watchdog rate codes
   localparam logic [7:0] RST_PLL_MULT    = 8'h00;
   localparam logic [7:0] RST_REF_DIV     = 8'h00;
   localparam logic [7:0] RST_POST_DIV    = 8'h03;
   localparam logic [7:0] RST_CTRL        = 8'h00;
   localparam logic [2:0] WDOG_RATE_MAX   = 3'h7;
   localparam logic [2:0] WDOG_RATE_OFF   = 3'h0;
   // timing: reset pin pulse stretch; counter widths
   localparam int RST_PULSE_NS            = 64;
   localparam int CLK_PERIOD_NS           = 4;
   localparam int RST_PULSE_CYC           = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RTI_W                   = 16;
   localparam int WDOG_W                  = 24;
endpackage : cpu_pkg

// *** hdl/cpu_sync2.sv ***
/*
 * two-flop synchroniser for one level from outside the clock domain.
 * assumes a free-running clock; the enable freezes both stages.
 */
`timescale 1ns/10ps
module cpu_sync2 (
   input  wire logic ref_clk_i,   // system clock
   input  wire logic clk_en_i,    // clock enable
   input  wire logic d_i,         // async level
   output logic      q_o          // synchronised level
);
   logic meta;

   always_ff @(posedge ref_clk_i) begin
      if (clk_en_i) begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : cpu_sync2

// *** testbench/cpu_far_model.sv ***
/*
 * far side of the clock and power unit slice: crystal resonator and the
 * shared active-low reset line with its pull-up.
 * assumes the unit drives the reset pin open drain through its enable.
 */
`timescale 1ns/10ps
module cpu_far_model #(
   parameter int CRYSTAL_OUTPUT_PIN_HALF_NS = 40                  // resonator half period
) (
   input  wire logic reset_pin_drv_i,               // unit reset pin value
   input  wire logic reset_pin_oe_i,                // unit pulls pin low
   input  wire logic crystal_pulldown_i,            // crystal pin pull-downs on
   input  wire logic ext_reset_i,                   // outside party pulls reset low
   output logic      reset_line_o,                  // resolved reset pin level
   output logic      crystal_o                      // crystal input pin level
);
   logic osc;

   initial begin
      osc = 1'b0;
      forever #(CRYSTAL_OUTPUT_PIN_HALF_NS) osc = ~osc;
   end

   // pulled-down pin shows no swing
   assign crystal_o    = crystal_pulldown_i ? 1'b0 : osc;
   // pull-up unless the unit or an outside party pulls low
   assign reset_line_o = (reset_pin_oe_i ? reset_pin_drv_i : 1'b1) & ~ext_reset_i;
endmodule : cpu_far_model

// *** testbench/tb_top.sv ***
/*
 * self-checking bench for the clock and power unit slice.
 * assumes the register port answers one cycle after the read strobe.
 */
`timescale 1ns/10ps
module tb_top;
   logic       ref_clk_i, reset_n_i, wr_i, rd_i, dbg, fmax, int_req, src_a, src_b, ext_low;
   logic [9:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rv;
   logic       rst_o, rst_oe, arst_n, crystal_output_pin, oclk, pd, per_o, per_oe, sense, realtime_interrupt, wdt, rst_pin;
   int         err_count, n_compared, hits, rti_hits;
   logic [9:0] a_tab [12] = '{cpu_pkg::OFF_PLL_MULT, cpu_pkg::OFF_REF_DIV, cpu_pkg::OFF_POST_DIV,
      cpu_pkg::OFF_INT_EN, cpu_pkg::OFF_CLK_SEL, cpu_pkg::OFF_FREQ_MOD, cpu_pkg::OFF_RTI_RATE,
      cpu_pkg::OFF_RSVD_A, cpu_pkg::OFF_RSVD_B, cpu_pkg::OFF_WDOG_SVC, cpu_pkg::OFF_LV_CTL, 10'h100};
   logic [7:0] m_tab [12] = '{8'hff, cpu_pkg::MASK_REF_DIV, cpu_pkg::MASK_POST_DIV, cpu_pkg::MASK_INT_EN,
      8'hff, cpu_pkg::MASK_FREQ_MOD, 8'hff, 8'h00, 8'h00, 8'h00, cpu_pkg::MASK_LV_CTL, 8'h00};

   cpu_unit dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .background_debug_i(dbg),
      .force_wdog_max_i(fmax), .int_reset_req_i(int_req), .reset_pin_i(rst_pin),
      .reset_pin_o(rst_o), .reset_pin_oe_o(rst_oe), .async_reset_n_o(arst_n),
      .crystal_input_pin_i(crystal_output_pin), .loop_oscillator_clock_o(oclk), .crystal_pulldown_o(pd),
      .periodic_src_a_i(src_a), .periodic_src_b_i(src_b), .periodic_clock_out_pin_o(per_o),
      .periodic_clock_out_oe_o(per_oe), .sense_voltage_select_o(sense), .rti_tick_o(realtime_interrupt),
      .wdog_timeout_o(wdt));

   cpu_far_model far (.reset_pin_drv_i(rst_o), .reset_pin_oe_i(rst_oe), .crystal_pulldown_i(pd),
      .ext_reset_i(ext_low), .reset_line_o(rst_pin), .crystal_o(crystal_output_pin));

   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : cyc

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i   <= 1'b0;
      @(negedge ref_clk_i);
      d = rdata_o;
   endtask : rd

   // counts watchdog expiry pulses over n cycles
   task automatic count_wdt(input int n);
      hits = 0;
      rti_hits = 0;
      repeat (n) begin
         @(posedge ref_clk_i);
         if (wdt === 1'b1) hits++;
         if (realtime_interrupt === 1'b1) rti_hits++;
      end
   endtask : count_wdt

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   initial begin
      #200us;
      err_count++;
      report_and_stop();
   end

   initial begin
      {reset_n_i, wr_i, rd_i, dbg, fmax, int_req, src_a, src_b, ext_low} = '0;
      addr_i = '0;
      wdata_i = '0;
      err_count = 0;
      n_compared = 0;
      cyc(2);
      reset_n_i <= 1'b1;
      chk("pulldown_rst", 8'(pd), 8'h01);
      for (int i = 0; i < 12; i++) begin
         rd(a_tab[i], rv);
         chk("reset_val", rv, (a_tab[i] == cpu_pkg::OFF_POST_DIV) ? cpu_pkg::RST_POST_DIV : 8'h00);
         wr(a_tab[i], 8'hff);
         rd(a_tab[i], rv);
         chk("masked_rb", rv, m_tab[i]);
         wr(a_tab[i], 8'h00);
      end
      wr(cpu_pkg::OFF_TEMP_CTL, 8'hff);
      rd(cpu_pkg::OFF_TEMP_CTL, rv);
      chk("temp_rb", rv, cpu_pkg::MASK_TEMP_CTL);
      cyc(3);
      chk("sense_hi", 8'(sense), 8'h01);
      wr(cpu_pkg::OFF_TEMP_CTL, 8'h00);
      cyc(3);
      chk("sense_lo", 8'(sense), 8'h00);
      $display("test registers and sense select done");

      src_a <= 1'b1;
      wr(cpu_pkg::OFF_PER_CTL, 8'h08);
      cyc(5);
      chk("per_oe_on", 8'(per_oe), 8'h01);
      chk("per_src_a", 8'(per_o), 8'h01);
      wr(cpu_pkg::OFF_PER_CTL, 8'h18);
      cyc(5);
      chk("per_src_b0", 8'(per_o), 8'h00);
      src_b <= 1'b1;
      cyc(5);
      chk("per_src_b1", 8'(per_o), 8'h01);
      wr(cpu_pkg::OFF_PER_CTL, 8'h10);
      cyc(5);
      chk("per_oe_off", 8'(per_oe), 8'h00);
      chk("per_gated", 8'(per_o), 8'h00);
      $display("test periodic clock pin done");

      wr(cpu_pkg::OFF_OSC_CTL, 8'h80);
      cyc(3);
      chk("pulldown_off", 8'(pd), 8'h00);
      @(posedge crystal_output_pin);
      cyc(6);
      chk("osc_clk_hi", 8'(oclk), 8'h01);
      @(negedge crystal_output_pin);
      cyc(6);
      chk("osc_clk_lo", 8'(oclk), 8'h00);
      wr(cpu_pkg::OFF_OSC_CTL, 8'h00);
      cyc(3);
      chk("pulldown_on", 8'(pd), 8'h01);
      $display("test crystal pins done");

      @(posedge ref_clk_i);
      int_req <= 1'b1;
      @(posedge ref_clk_i);
      int_req <= 1'b0;
      cyc(3);
      chk("rst_drive", 8'({rst_oe, rst_o, rst_pin}), 8'h04);
      chk("rst_self", 8'(arst_n), 8'h01);
      repeat (cpu_pkg::RST_PULSE_CYC + 4) begin
         @(posedge ref_clk_i);
         chk("rst_self_hold", 8'(arst_n), 8'h01);
      end
      chk("rst_release", 8'(rst_oe), 8'h00);
      cyc(4);
      ext_low <= 1'b1;
      cyc(5);
      chk("ext_rst_lo", 8'(arst_n), 8'h00);
      ext_low <= 1'b0;
      cyc(5);
      chk("ext_rst_hi", 8'(arst_n), 8'h01);
      $display("test reset pin done");

      dbg <= 1'b1;
      wr(cpu_pkg::OFF_WDOG_CTL, 8'h01);
      wr(cpu_pkg::OFF_RTI_RATE, 8'h01);
      count_wdt(2200);
      chk("wdog_runs_dbg", 8'(hits != 0), 8'h01);
      chk("rti_runs_dbg", 8'(rti_hits != 0), 8'h01);
      wr(cpu_pkg::OFF_WDOG_CTL, 8'h41);
      rd(cpu_pkg::OFF_WDOG_CTL, rv);
      chk("wdog_ctl_rb", rv, 8'h41);
      count_wdt(3000);
      chk("wdog_halted", 8'(hits), 8'h00);
      chk("rti_halted", 8'(rti_hits), 8'h00);
      fmax <= 1'b1;
      wr(cpu_pkg::OFF_WDOG_CTL, 8'h01);
      count_wdt(3000);
      chk("wdog_forced_max", 8'(hits), 8'h00);
      chk("rti_runs_unfrozen", 8'(rti_hits != 0), 8'h01);
      fmax <= 1'b0;
      dbg  <= 1'b0;
      wr(cpu_pkg::OFF_WDOG_CTL, 8'h00);
      $display("test debug freeze done");
      report_and_stop();
   end
endmodule : tb_top
